// [hw/cmesc_ctrl.sv]
// Escape controller: spots guard/escape/guard in the byte stream,
// runs command mode, holds settings and
// drives both auxiliary lines.
// Assumes bytes and commands arrive from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cmesc_ctrl #(
    parameter int unsigned TICK_CYC = cmesc_pkg::TICK_CYCLES
) (
    input  wire logic        clock_in,           // 40 MHz clock
    input  wire logic        sys_rst_in,         // Async reset, active high
    input  wire logic        rx_valid_in,        // Byte from serial input
    input  wire logic [7:0]  rx_byte_in,         // Received byte
    input  wire logic        cmd_valid_in,       // Parsed command strobe
    input  wire logic [7:0]  cmd_code_in,        // Command code
    input  wire logic        cmd_has_param_in,   // Parameter present
    input  wire logic [15:0] cmd_param_in,       // Parameter value
    input  wire logic        flow_ready_in,      // Receive buffer has room
    input  wire logic        tx_active_in,       // Line driver needed
    input  wire logic        rx_activity_in,     // Receiving a packet
    input  wire logic        rx_addressed_in,    // Packet is for us
    output logic             data_valid_out,     // Byte passed as data
    output logic [7:0]       data_out,           // Passed byte
    output logic             rsp_valid_out,      // Command answer strobe
    output logic             rsp_ok_out,         // Command accepted
    output logic [15:0]      rsp_data_out,       // Stored value
    output logic             command_mode_out,   // In command mode
    output logic [15:0]      serial_rate_out,    // Applied rate setting
    output logic             second_aux_output_out,
    output logic             third_aux_output_out
);
    import cmesc_pkg::*;

    // Whole state of the controller
    typedef struct packed {
        cmesc_state_t state;   // Mode
        logic [15:0]  sil;     // Ticks of silence / inactivity
        logic [15:0]  bt;      // guard_before_time
        logic [15:0]  at;      // guard_after_time
        logic [15:0]  ct;      // command_mode_timeout
        logic [7:0]   cc;      // escape_character
        logic [7:0]   cs;      // second_output_config
        logic [7:0]   cd;      // third_output_config
        logic [15:0]  bd_pend; // Rate written, not yet applied
        logic [15:0]  bd_act;  // Rate in use
        logic         rsp_v;
        logic         rsp_ok;
        logic [15:0]  rsp_d;
        logic         dat_v;
        logic [7:0]   dat;
        logic         aux2;
        logic         aux3;
    } cmesc_ctrl_t;

    localparam cmesc_ctrl_t RST = '{
        state: ST_IDLE, sil: '0, bt: BT_RST, at: AT_RST, ct: CT_RST,
        cc: CC_RST, cs: CS_RST, cd: CD_RST, bd_pend: BD_RST,
        bd_act: BD_RST, rsp_v: 1'b0, rsp_ok: 1'b0, rsp_d: '0,
        dat_v: 1'b0, dat: '0, aux2: 1'b0, aux3: 1'b0
    };

    cmesc_ctrl_t r, n;
    logic        tick;     // 100 ms pulse
    logic        restart;  // Realign timebase

    // Range check shared by every setting
    function automatic logic in_range(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    // Timebase restarts on activity or mode change
    cmesc_tick #(
        .CYCLES     (TICK_CYC)
    ) u_tick (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .restart_in (restart),
        .tick_out   (tick)
    );

    assign restart = rx_valid_in
                   || (cmd_valid_in && (r.state == ST_CMD))
                   || (n.state != r.state);

    // Next-state logic
    always_comb begin
        n       = r;
        n.rsp_v = 1'b0;
        n.dat_v = 1'b0;
        // Silence counter runs on ticks and saturates
        if (tick && (r.sil != SIL_MAX)) begin
            n.sil = r.sil + 16'h0001;
        end
        unique case (r.state)
            ST_IDLE: begin
                if (rx_valid_in) begin
                    n.dat_v = 1'b1;                          // R12
                    n.dat   = rx_byte_in;
                    n.sil   = '0;
                    // Escape only counts after a long enough silence
                    if ((rx_byte_in == r.cc) && (r.sil >= r.bt)) begin
                        n.state = ST_GUARD;                  // R01 R02 R03
                    end
                end
            end
            ST_GUARD: begin
                if (rx_valid_in) begin
                    // Any byte breaks the guard; it stays ordinary data
                    n.dat_v = 1'b1;                          // R12
                    n.dat   = rx_byte_in;
                    n.sil   = '0;
                    n.state = ST_IDLE;                       // R12
                end else if (r.sil >= r.at) begin
                    n.sil   = '0;
                    n.state = ST_CMD;                        // R03 R09
                end
            end
            ST_CMD: begin
                if (rx_valid_in) begin
                    n.sil = '0;                              // R04
                end
                if (cmd_valid_in) begin
                    n.sil    = '0;                           // R04
                    n.rsp_v  = 1'b1;
                    n.rsp_ok = 1'b1;
                    unique case (cmd_code_in)
                        CMD_BT: begin
                            if (!cmd_has_param_in) begin
                                n.rsp_d = r.bt;              // R10
                            end else if (in_range(cmd_param_in, TIME_MIN,
                                                  TIME_MAX)) begin
                                n.bt    = cmd_param_in;      // R01
                                n.rsp_d = cmd_param_in;
                            end else begin
                                n.rsp_ok = 1'b0;
                                n.rsp_d  = r.bt;
                            end
                        end
                        CMD_AT: begin
                            if (!cmd_has_param_in) begin
                                n.rsp_d = r.at;              // R10
                            end else if (in_range(cmd_param_in, TIME_MIN,
                                                  TIME_MAX)) begin
                                n.at    = cmd_param_in;      // R09
                                n.rsp_d = cmd_param_in;
                            end else begin
                                n.rsp_ok = 1'b0;
                                n.rsp_d  = r.at;
                            end
                        end
                        CMD_CT: begin
                            if (!cmd_has_param_in) begin
                                n.rsp_d = r.ct;              // R10
                            end else if (in_range(cmd_param_in, TIME_MIN,
                                                  TIME_MAX)) begin
                                n.ct    = cmd_param_in;      // R04
                                n.rsp_d = cmd_param_in;
                            end else begin
                                // Too short a timeout would lock users out
                                n.rsp_ok = 1'b0;             // R08
                                n.rsp_d  = r.ct;
                            end
                        end
                        CMD_CC: begin
                            if (!cmd_has_param_in) begin
                                n.rsp_d = {8'h00, r.cc};     // R10
                            end else if (in_range(cmd_param_in,
                                                  {8'h00, CC_MIN},
                                                  {8'h00, CC_MAX})) begin
                                n.cc    = cmd_param_in[7:0]; // R02
                                n.rsp_d = cmd_param_in;
                            end else begin
                                n.rsp_ok = 1'b0;
                                n.rsp_d  = {8'h00, r.cc};
                            end
                        end
                        CMD_CS: begin
                            if (!cmd_has_param_in) begin
                                n.rsp_d = {8'h00, r.cs};     // R10
                            end else if (in_range(cmd_param_in, '0,
                                                  {8'h00, CS_MAX})) begin
                                n.cs    = cmd_param_in[7:0]; // R06
                                n.rsp_d = cmd_param_in;
                            end else begin
                                n.rsp_ok = 1'b0;
                                n.rsp_d  = {8'h00, r.cs};
                            end
                        end
                        CMD_CD: begin
                            if (!cmd_has_param_in) begin
                                n.rsp_d = {8'h00, r.cd};     // R10
                            end else if (in_range(cmd_param_in, '0,
                                                  {8'h00, CD_MAX})) begin
                                n.cd    = cmd_param_in[7:0]; // R07
                                n.rsp_d = cmd_param_in;
                            end else begin
                                n.rsp_ok = 1'b0;
                                n.rsp_d  = {8'h00, r.cd};
                            end
                        end
                        CMD_BD: begin
                            if (!cmd_has_param_in) begin
                                n.rsp_d = r.bd_pend;         // R10
                            end else if (in_range(cmd_param_in, '0,
                                                  BD_STD_MAX)
                                      || in_range(cmd_param_in, BD_NS_MIN,
                                                  TIME_MAX)) begin
                                // Held back so the answer uses the old rate
                                n.bd_pend = cmd_param_in;    // R11
                                n.rsp_d   = cmd_param_in;
                            end else begin
                                n.rsp_ok = 1'b0;
                                n.rsp_d  = r.bd_pend;
                            end
                        end
                        CMD_CN: begin
                            n.rsp_d  = '0;
                            n.bd_act = r.bd_pend;            // R11
                            n.state  = ST_IDLE;              // R05
                        end
                        default: begin
                            // Unknown code: refused, nothing stored
                            n.rsp_ok = 1'b0;
                            n.rsp_d  = '0;
                        end
                    endcase
                end else if (!rx_valid_in && (r.sil >= r.ct)) begin
                    // Inactivity timeout; a pending rate is not applied
                    n.sil   = '0;
                    n.state = ST_IDLE;                       // R04
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
        if (n.state != r.state) begin
            n.sil = '0;
        end
        // Second auxiliary line
        unique case (r.cs)
            CS_CTS:     n.aux2 = !flow_ready_in;             // R06
            CS_TXEN_LO: n.aux2 = !tx_active_in;              // R06
            CS_HIGH:    n.aux2 = 1'b1;                       // R06
            CS_TXEN_HI: n.aux2 = tx_active_in;               // R06
            CS_LOW:     n.aux2 = 1'b0;                       // R06
            default:    n.aux2 = 1'b0;
        endcase
        // Third auxiliary line
        unique case (r.cd)
            CD_RXIND: n.aux3 = rx_activity_in;               // R07
            CD_HIGH:  n.aux3 = 1'b1;                         // R07
            CD_LOW:   n.aux3 = 1'b0;                         // R07
            CD_ADDR:  n.aux3 = rx_activity_in && rx_addressed_in; // R07
            default:  n.aux3 = 1'b0;
        endcase
    end

    // State register
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign data_valid_out        = r.dat_v;
    assign data_out              = r.dat;
    assign rsp_valid_out         = r.rsp_v;
    assign rsp_ok_out            = r.rsp_ok;
    assign rsp_data_out          = r.rsp_d;
    assign command_mode_out      = (r.state == ST_CMD);
    assign serial_rate_out       = r.bd_act;
    assign second_aux_output_out = r.aux2;
    assign third_aux_output_out  = r.aux3;

endmodule : cmesc_ctrl
`default_nettype wire

// [hw/cmesc_tick.sv]
// Restartable 100 ms timebase for the escape controller.
// Assumes restart comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cmesc_tick #(
    parameter int unsigned CYCLES = cmesc_pkg::TICK_CYCLES
) (
    input  wire logic clock_in,    // 40 MHz clock
    input  wire logic sys_rst_in,  // Async reset, active high
    input  wire logic restart_in,  // Start a fresh period
    output logic      tick_out     // One-cycle pulse per period
);
    import cmesc_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;   // Cycles into the current period
        logic        tick;  // Registered tick
    } cmesc_tick_t;

    localparam logic [31:0] LAST = 32'(CYCLES - 1);

    cmesc_tick_t r, n;

    // Restart aligns periods to the last activity so silences are exact
    always_comb begin
        n      = r;
        n.tick = 1'b0;
        if (restart_in) begin
            n.cnt = '0;
        end else if (r.cnt == LAST) begin
            n.cnt  = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick_out = r.tick;

endmodule : cmesc_tick
`default_nettype wire

// [include/cmesc_pkg.sv]
// Constants, types and codes of the command-mode escape controller.
// Assumes a 40 MHz clock and a binary command port fed by a command parser.
// Operation
// R01: Silence of guard-before time precedes escape character
// R02: Escape character programmable 0x20-0x7F, reset 0x2B
// R03: Enter command mode only after full sequence
// R04: Command mode ends after inactivity timeout
// R05: Exit command returns to idle at once
// R06: Second output selects flow control or transmit enable
// R07: Third output selects receive indicator or levels
// R08: Timeout settings below minimum are rejected
// R09: Silence of guard-after time completes sequence
// R10: Command without parameter answers stored value
// R11: New serial rate applies only on exit
// R12: Broken sequence restarts detection, bytes stay data
package cmesc_pkg;

    // Timebase: one tick per 100 ms
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned TICK_MS     = 100;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // Command codes, which double as register offsets
    localparam logic [7:0] CMD_BT = 8'h04;  // guard_before_time
    localparam logic [7:0] CMD_AT = 8'h05;  // guard_after_time
    localparam logic [7:0] CMD_CT = 8'h06;  // command_mode_timeout
    localparam logic [7:0] CMD_CN = 8'h09;  // exit_command_mode
    localparam logic [7:0] CMD_CC = 8'h13;  // escape_character
    localparam logic [7:0] CMD_BD = 8'h15;  // serial_rate_setting
    localparam logic [7:0] CMD_CS = 8'h1F;  // second_output_config
    localparam logic [7:0] CMD_CD = 8'h28;  // third_output_config

    // Reset values
    localparam logic [15:0] BT_RST = 16'h000A;
    localparam logic [15:0] AT_RST = 16'h000A;
    localparam logic [15:0] CT_RST = 16'h00C8;
    localparam logic [7:0]  CC_RST = 8'h2B;
    localparam logic [7:0]  CS_RST = 8'h00;
    localparam logic [7:0]  CD_RST = 8'h00;
    localparam logic [15:0] BD_RST = 16'h0003;  // Factory rate, arbitrary

    // Legal ranges
    localparam logic [15:0] TIME_MIN = 16'h0002;
    localparam logic [15:0] TIME_MAX = 16'hFFFF;
    localparam logic [7:0]  CC_MIN   = 8'h20;
    localparam logic [7:0]  CC_MAX   = 8'h7F;
    localparam logic [7:0]  CS_MAX   = 8'h04;
    localparam logic [7:0]  CD_MAX   = 8'h03;
    localparam logic [15:0] BD_STD_MAX = 16'h0006;
    localparam logic [15:0] BD_NS_MIN  = 16'h007D;

    // Second output selections
    localparam logic [7:0] CS_CTS     = 8'h00;
    localparam logic [7:0] CS_TXEN_LO = 8'h01;
    localparam logic [7:0] CS_HIGH    = 8'h02;
    localparam logic [7:0] CS_TXEN_HI = 8'h03;
    localparam logic [7:0] CS_LOW     = 8'h04;

    // Third output selections
    localparam logic [7:0] CD_RXIND = 8'h00;
    localparam logic [7:0] CD_HIGH  = 8'h01;
    localparam logic [7:0] CD_LOW   = 8'h02;
    localparam logic [7:0] CD_ADDR  = 8'h03;

    localparam logic [15:0] SIL_MAX = 16'hFFFF;  // Silence counter saturates

    // Mode states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,  // Data mode, watching for escape
        ST_GUARD = 3'b010,  // Escape seen, timing guard-after
        ST_CMD   = 3'b100   // Command mode
    } cmesc_state_t;

endpackage : cmesc_pkg

// [verif/cmesc_ctrl_chk.sv]
// Port checker for the escape controller.
// Bound to cmesc_ctrl; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cmesc_chk #(
    parameter int unsigned TICK_CYC = 10  // Cycles per 100 ms tick
) (
    input wire logic        clock_in,
    input wire logic        sys_rst_in,
    input wire logic        rx_valid_in,
    input wire logic [7:0]  rx_byte_in,
    input wire logic        cmd_valid_in,
    input wire logic [7:0]  cmd_code_in,
    input wire logic        cmd_has_param_in,
    input wire logic [15:0] cmd_param_in,
    input wire logic        data_valid_out,
    input wire logic [7:0]  data_out,
    input wire logic        rsp_valid_out,
    input wire logic        rsp_ok_out,
    input wire logic [15:0] serial_rate_out,
    input wire logic        command_mode_out
);
    import cmesc_pkg::*;
    logic [15:0] quiet_r;  // Cycles since last byte
    logic        cmd_now;  // Command taken now

    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    assign cmd_now = cmd_valid_in && command_mode_out;

    // Saturating silence count, simpler than ticks
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            quiet_r <= 16'h0000;
        end else if (rx_valid_in) begin
            quiet_r <= 16'h0000;  // Any byte breaks the silence
        end else if (quiet_r != 16'hFFFF) begin
            quiet_r <= quiet_r + 16'h0001;
        end
    end

    // Guard-after is at least two ticks of silence
    a_enter_after_quiet: assert property ($rose(command_mode_out) |->
        32'(quiet_r) >= 2 * TICK_CYC) else $error("mode entered early");
    a_data_pass_on: assert property (rx_valid_in && !command_mode_out
        ##1 !command_mode_out |-> data_valid_out
        && data_out == $past(rx_byte_in)) else $error("byte not passed");
    a_cmd_byte_held: assert property (rx_valid_in && command_mode_out
        |=> !data_valid_out) else $error("byte leaked");
    a_rsp_one_cycle: assert property (cmd_now |=> rsp_valid_out)
        else $error("no answer");
    a_no_rsp_idle: assert property (!command_mode_out |=>
        !rsp_valid_out) else $error("stray answer");
    a_exit_at_once: assert property (cmd_now && cmd_code_in == CMD_CN
        |=> !command_mode_out && rsp_ok_out) else $error("exit late");
    a_rate_held: assert property (!(cmd_now && cmd_code_in == CMD_CN)
        |=> $stable(serial_rate_out)) else $error("rate early");
    a_ct_low_refused: assert property (cmd_now && cmd_has_param_in
        && cmd_code_in == CMD_CT && cmd_param_in < TIME_MIN
        |=> rsp_valid_out && !rsp_ok_out) else $error("low timeout");
    a_cc_range_refused: assert property (cmd_now && cmd_has_param_in
        && cmd_code_in == CMD_CC && (cmd_param_in < 16'(CC_MIN)
        || cmd_param_in > 16'(CC_MAX)) |=> !rsp_ok_out)
        else $error("bad escape kept");
endmodule : cmesc_chk

bind cmesc_ctrl cmesc_chk #(.TICK_CYC(TICK_CYC)) u_chk (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in),
    .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
    .cmd_has_param_in(cmd_has_param_in), .cmd_param_in(cmd_param_in),
    .data_valid_out(data_valid_out), .data_out(data_out),
    .rsp_valid_out(rsp_valid_out), .rsp_ok_out(rsp_ok_out),
    .serial_rate_out(serial_rate_out),
    .command_mode_out(command_mode_out));
`default_nettype wire

// [verif/cmesc_host.sv]
// Host model feeding the controller's byte input.
// Assumes bench calls; bytes change after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module cmesc_host (
    input  wire logic  clock_in,      // 40 MHz clock
    output logic       rx_valid_out,  // Byte strobe
    output logic [7:0] rx_byte_out    // Byte, valid with strobe
);
    // Idle pattern, not a held value
    initial begin
        rx_valid_out = 1'b0;
        rx_byte_out  = 8'hA5;
    end

    // One-cycle byte, then the inverse
    task automatic send(input logic [7:0] b);
        @(posedge clock_in);
        rx_valid_out <= 1'b1;
        rx_byte_out  <= b;
        @(posedge clock_in);
        rx_valid_out <= 1'b0;
        rx_byte_out  <= ~b;
    endtask : send

    // Silence around the escape
    task automatic quiet(input int n);
        repeat (n) @(posedge clock_in);
    endtask : quiet
endmodule : cmesc_host
`default_nettype wire

// [verif/test_command_mode_escape_control.sv]
// Self-checking bench for the escape controller.
// Assumes a 10-cycle tick to keep waits short.
`timescale 1ns/1ps
`default_nettype none
module test_command_mode_escape_control;
    import cmesc_pkg::*;
    localparam logic [7:0]  QC [7] = '{CMD_BT, CMD_AT, CMD_CT, CMD_CC,
                                       CMD_CS, CMD_CD, CMD_BD};
    localparam logic [15:0] QV [7] = '{BT_RST, AT_RST, CT_RST, 16'(CC_RST),
                                       16'(CS_RST), 16'(CD_RST), BD_RST};
    localparam logic [4:0]  CSX [3] = '{5'h06, 5'h0D, 5'h0C};  // Per input set
    localparam logic [3:0]  CDX [3] = '{4'h3, 4'h2, 4'hB};
    logic        clock_in, sys_rst_in, cmd_valid_in, cmd_has_param_in;
    logic        flow_ready_in, tx_active_in, rx_activity_in;
    logic        rx_addressed_in, rx_valid, data_valid_out, rsp_valid_out;
    logic        rsp_ok_out, command_mode_out, aux2, aux3;
    logic [7:0]  cmd_code_in, rx_byte, data_out;
    logic [15:0] cmd_param_in, rsp_data_out, serial_rate_out;
    int          fail_count, total_checks;

    cmesc_host HOST (.clock_in(clock_in), .rx_valid_out(rx_valid),
                     .rx_byte_out(rx_byte));
    cmesc_ctrl #(.TICK_CYC(10)) DUT (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .rx_valid_in(rx_valid), .rx_byte_in(rx_byte),
        .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
        .cmd_has_param_in(cmd_has_param_in), .cmd_param_in(cmd_param_in),
        .flow_ready_in(flow_ready_in), .tx_active_in(tx_active_in),
        .rx_activity_in(rx_activity_in), .rx_addressed_in(rx_addressed_in),
        .data_valid_out(data_valid_out), .data_out(data_out),
        .rsp_valid_out(rsp_valid_out), .rsp_ok_out(rsp_ok_out),
        .rsp_data_out(rsp_data_out), .command_mode_out(command_mode_out),
        .serial_rate_out(serial_rate_out),
        .second_aux_output_out(aux2), .third_aux_output_out(aux3));

    // Free-running 25 ns clock
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // One command; answer due next cycle
    task automatic cmd(input logic [7:0] c, input logic p,
                       input logic [15:0] v);
        @(posedge clock_in);
        cmd_valid_in <= 1'b1;
        cmd_code_in <= c;
        cmd_has_param_in <= p;
        cmd_param_in <= v;
        @(posedge clock_in);
        cmd_valid_in <= 1'b0;
        #1;
        check(rsp_valid_out, 1'b1);
    endtask : cmd

    // Bounded mode wait; a hang ends the run
    task automatic wait_mode(input logic v, input int n);
        int i = 0;
        while (command_mode_out !== v && i < n) begin
            @(posedge clock_in);
            #1;
            i++;
        end
        check(command_mode_out, v);
        if (command_mode_out !== v) conclude();
    endtask : wait_mode

    // Full guard, escape, guard sequence
    task automatic enter(input logic [7:0] ch);
        HOST.quiet(110);
        HOST.send(ch);
        #1;
        check(data_out, ch);
        repeat (90) @(posedge clock_in);
        #1;
        check(command_mode_out, 1'b0);
        wait_mode(1'b1, 40);
    endtask : enter

    task automatic t_defaults();
        enter(CC_RST);
        for (int i = 0; i < 7; i++) begin
            cmd(QC[i], 1'b0, 16'h0000);
            check(rsp_data_out, QV[i]);
        end
        cmd(CMD_CT, 1'b1, 16'h0001);
        check(rsp_ok_out, 1'b0);
        cmd(CMD_CT, 1'b0, 16'h0000);
        check(rsp_data_out, CT_RST);
        cmd(CMD_CC, 1'b1, 16'h001F);
        check(rsp_ok_out, 1'b0);
        cmd(CMD_CC, 1'b1, 16'h0080);
        check(rsp_ok_out, 1'b0);
    endtask : t_defaults

    // Every selection, three input sets
    task automatic t_aux();
        for (int k = 0; k < 5; k++) begin
            cmd(CMD_CS, 1'b1, 16'(k));
            if (k < 4) cmd(CMD_CD, 1'b1, 16'(k));
            for (int j = 0; j < 3; j++) begin
                @(posedge clock_in);
                flow_ready_in <= (j != 1);
                rx_activity_in <= (j != 1);
                tx_active_in <= (j != 0);
                rx_addressed_in <= (j != 0);
                repeat (2) @(posedge clock_in);
                #1;
                check(aux2, CSX[j][k]);
                if (k < 4) check(aux3, CDX[j][k]);
            end
        end
    endtask : t_aux

    task automatic t_rate_exit();
        cmd(CMD_BD, 1'b1, 16'h0005);
        check(serial_rate_out, BD_RST);
        cmd(CMD_CN, 1'b0, 16'h0000);
        check(command_mode_out, 1'b0);
        check(serial_rate_out, 16'h0005);
    endtask : t_rate_exit

    // Byte in guard-after, then a wrong escape
    task automatic t_broken();
        HOST.quiet(110);
        HOST.send(CC_RST);
        HOST.quiet(30);
        HOST.send(8'h41);
        #1;
        check(data_valid_out, 1'b1);
        check(data_out, 8'h41);
        HOST.quiet(110);
        HOST.send(8'h2A);
        HOST.quiet(150);
        #1;
        check(command_mode_out, 1'b0);
    endtask : t_broken

    // Shortest timeout, byte restart, new escape
    task automatic t_timeout();
        enter(CC_RST);
        cmd(CMD_CC, 1'b1, 16'h007E);
        check(rsp_ok_out, 1'b1);
        cmd(CMD_CT, 1'b1, 16'h0002);
        check(rsp_ok_out, 1'b1);
        HOST.quiet(12);
        HOST.send(8'h41);
        repeat (15) @(posedge clock_in);
        #1;
        check(command_mode_out, 1'b1);
        wait_mode(1'b0, 30);
        enter(8'h7E);
        cmd(CMD_CN, 1'b0, 16'h0000);
    endtask : t_timeout

    // Two-cycle reset, then each scenario
    initial begin
        fail_count = 0;
        total_checks = 0;
        sys_rst_in = 1'b1;
        cmd_valid_in = 1'b0;
        cmd_code_in = 8'h00;
        cmd_has_param_in = 1'b0;
        cmd_param_in = 16'h0000;
        flow_ready_in = 1'b1;
        tx_active_in = 1'b0;
        rx_activity_in = 1'b0;
        rx_addressed_in = 1'b0;
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        #1;
        check(serial_rate_out, BD_RST);
        t_defaults();
        t_aux();
        t_rate_exit();
        t_broken();
        t_timeout();
        conclude();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock_in);
        fail_count++;
        conclude();
    end
endmodule : test_command_mode_escape_control
`default_nettype wire
